//--- include/scpip_map.vh
// Constants for the command text parser: character codes, lengths and states.
// Assumes 8-bit ASCII characters arrive one per clock from the system bus side.
`ifndef SCPIP_MAP_VH
`define SCPIP_MAP_VH

// =====================================================================
// Character codes
`define SCPIP_CH_STAR 8'h2A
`define SCPIP_CH_COLON 8'h3A
`define SCPIP_CH_SEMI 8'h3B
`define SCPIP_CH_SPACE 8'h20
`define SCPIP_CH_QUERY 8'h3F
`define SCPIP_CH_NL 8'h0A
`define SCPIP_CH_LC_A 8'h61
`define SCPIP_CH_LC_Z 8'h7A
`define SCPIP_CASE_BIT 8'h20

// =====================================================================
// Keyword sizes
`define SCPIP_KEY_MAX 4'h0C
`define SCPIP_COMMON_MIN 4'h4
`define SCPIP_COMMON_MAX 4'h5
`define SCPIP_NUM_KEYS 14
`define SCPIP_ID_NONE 4'h0

// =====================================================================
// Parser states
`define SCPIP_ST_KEY 2'b00
`define SCPIP_ST_PARAM 2'b01
`define SCPIP_ST_SKIP 2'b10

`endif

//--- logic/scpip_key_match.v
// Keyword table and matcher: compares one upper-cased keyword with every entry.
// Assumes the keyword is held newest character in the low byte, at most twelve bytes.
`include "scpip_map.vh"
`timescale 1ns/1ps

module scpip_key_match (
	key_buf,
	key_len,
	match_hit,
	match_id,
	match_implied
);
	input wire [95:0] key_buf;
	input wire [3:0] key_len;
	output reg match_hit;
	output reg [3:0] match_id;
	output reg match_implied;

	// =====================================================================
	// Table: {implied root child, short length, long length, zero padded long text}.
	function [104:0] entry;
		input integer idx;
		begin
			case (idx)
				1: entry = {1'b0, 4'h4, 4'h6, 48'h0000_0000_0000, "SOURCE"};
				2: entry = {1'b1, 4'h4, 4'h8, 32'h0000_0000, "FUNCTION"};
				3: entry = {1'b0, 4'h4, 4'h5, 56'h00_0000_0000_0000, "SHAPE"};
				4: entry = {1'b1, 4'h4, 4'h9, 24'h00_0000, "FREQUENCY"};
				5: entry = {1'b0, 4'h3, 4'hB, 8'h00, "CALIBRATION"};
				6: entry = {1'b0, 4'h3, 4'h6, 48'h0000_0000_0000, "SECURE"};
				7: entry = {1'b0, 4'h4, 4'h5, 56'h00_0000_0000_0000, "STATE"};
				8: entry = {1'b0, 4'h4, 4'h4, 64'h0000_0000_0000_0000, "CODE"};
				9: entry = {1'b0, 4'h4, 4'h5, 56'h00_0000_0000_0000, "COUNT"};
				10: entry = {1'b0, 4'h4, 4'h6, 48'h0000_0000_0000, "OUTPUT"};
				11: entry = {1'b0, 4'h4, 4'h7, 40'h00_0000_0000, "TRIGGER"};
				12: entry = {1'b0, 4'h4, 4'h6, 48'h0000_0000_0000, "SYSTEM"};
				13: entry = {1'b0, 4'h3, 4'h5, 56'h00_0000_0000_0000, "ERROR"};
				default: entry = {1'b0, 4'h4, 4'h4, 64'h0000_0000_0000_0000, "LOAD"};
			endcase
		end
	endfunction

	// =====================================================================
	// Per entry match against the exact long form or the exact short form.
	wire [`SCPIP_NUM_KEYS-1:0] hit;
	wire [`SCPIP_NUM_KEYS-1:0] impl;

	genvar g;
	generate
		for (g = 0; g < `SCPIP_NUM_KEYS; g = g + 1) begin : g_key
			wire [104:0] e = entry(g + 1);
			wire [3:0] short_len = e[103:100];
			wire [3:0] long_len = e[99:96];
			wire [95:0] short_txt = e[95:0] >> {long_len - short_len, 3'b000};
			reg same_long;
			reg same_short;
			integer j;
			always @* begin
				same_long = 1'b1;
				same_short = 1'b1;
				for (j = 0; j < 12; j = j + 1) begin
					if (j < key_len) begin
						if (key_buf[8*j +: 8] != e[8*j +: 8])
							same_long = 1'b0;
						if (key_buf[8*j +: 8] != short_txt[8*j +: 8])
							same_short = 1'b0;
					end
				end
			end
			// Only the two exact spellings select the entry.
			assign hit[g] = (key_len == long_len && same_long) ||
				(key_len == short_len && same_short);
			assign impl[g] = e[104];
		end
	endgenerate

	integer k;
	always @* begin
		match_hit = 1'b0;
		match_id = `SCPIP_ID_NONE;
		match_implied = 1'b0;
		for (k = 0; k < `SCPIP_NUM_KEYS; k = k + 1) begin
			if (hit[k] && !match_hit) begin
				match_hit = 1'b1;
				match_id = k[3:0] + 4'h1;
				match_implied = impl[k];
			end
		end
	end

endmodule

//--- logic/scpip_parser.v
// Command text parser: splits command lines into keywords, parameters and events.
// Assumes characters come from logic on clk, one per cycle while char_valid is high.
`include "scpip_map.vh"
`timescale 1ns/1ps

module scpip_parser #(
	parameter LEVEL_W = 3
) (
	clk,
	sys_rst,
	char_valid,
	char_data,
	kw_valid,
	kw_id,
	kw_level,
	kw_text,
	kw_common,
	kw_query,
	kw_implied,
	param_valid,
	param_data,
	cmd_end,
	cmd_default,
	resp_req,
	cmd_error
);
	input wire clk;
	input wire sys_rst;
	input wire char_valid;
	input wire [7:0] char_data;
	output reg kw_valid;
	output reg [3:0] kw_id;
	output reg [LEVEL_W-1:0] kw_level;
	output reg [95:0] kw_text;
	output reg kw_common;
	output reg kw_query;
	output reg kw_implied;
	output reg param_valid;
	output reg [7:0] param_data;
	output reg cmd_end;
	output reg cmd_default;
	output reg resp_req;
	output reg cmd_error;

	// =====================================================================
	// State.
	reg [1:0] state_q;
	reg [95:0] buf_q;
	reg [3:0] len_q;
	reg star_q;
	reg qry_q;
	reg ovf_q;
	reg cmd_qry_q;
	reg got_param_q;
	reg cmd_common_q;
	reg [LEVEL_W-1:0] level_q;

	// =====================================================================
	// Character classes.
	wire is_lower = char_data >= `SCPIP_CH_LC_A && char_data <= `SCPIP_CH_LC_Z;
	wire [7:0] ch_up = is_lower ? (char_data & ~`SCPIP_CASE_BIT) : char_data;
	wire is_colon = char_data == `SCPIP_CH_COLON;
	wire is_semi = char_data == `SCPIP_CH_SEMI;
	wire is_space = char_data == `SCPIP_CH_SPACE;
	wire is_nl = char_data == `SCPIP_CH_NL;
	wire is_query = char_data == `SCPIP_CH_QUERY;
	wire key_end = is_colon || is_semi || is_space || is_nl;
	wire cmd_stop = is_semi || is_nl;
	wire [3:0] common_len = len_q + {3'b000, qry_q};

	// =====================================================================
	// Keyword table lookup.
	wire match_hit;
	wire [3:0] match_id;
	wire match_implied;

	scpip_key_match u_match (
		.key_buf(buf_q),
		.key_len(len_q),
		.match_hit(match_hit),
		.match_id(match_id),
		.match_implied(match_implied)
	);

	// Keyword is good when common with legal length, or a table hit without overflow.
	wire common_ok = common_len >= `SCPIP_COMMON_MIN && common_len <= `SCPIP_COMMON_MAX;
	wire key_ok = star_q ? common_ok : (match_hit && !ovf_q);
	wire implied = !star_q && level_q == {LEVEL_W{1'b0}} && match_implied;

	// =====================================================================
	// Tree level bookkeeping.
	wire [LEVEL_W-1:0] key_level = level_q + {{(LEVEL_W-1){1'b0}}, implied};
	wire [LEVEL_W-1:0] child_level = key_level + {{(LEVEL_W-1){1'b0}}, 1'b1};
	wire level_full = &key_level;
	// A colon after a common or query keyword, or at the deepest level, is malformed.
	wire bad_colon = is_colon && (star_q || qry_q || level_full);

	// =====================================================================
	// Parser.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= `SCPIP_ST_KEY;
			buf_q <= 96'h0;
			len_q <= 4'h0;
			star_q <= 1'b0;
			qry_q <= 1'b0;
			ovf_q <= 1'b0;
			cmd_qry_q <= 1'b0;
			cmd_common_q <= 1'b0;
			got_param_q <= 1'b0;
			level_q <= {LEVEL_W{1'b0}};
			kw_valid <= 1'b0;
			kw_id <= 4'h0;
			kw_level <= {LEVEL_W{1'b0}};
			kw_text <= 96'h0;
			kw_common <= 1'b0;
			kw_query <= 1'b0;
			kw_implied <= 1'b0;
			param_valid <= 1'b0;
			param_data <= 8'h00;
			cmd_end <= 1'b0;
			cmd_default <= 1'b0;
			resp_req <= 1'b0;
			cmd_error <= 1'b0;
		end else begin
			kw_valid <= 1'b0;
			param_valid <= 1'b0;
			cmd_end <= 1'b0;
			resp_req <= 1'b0;
			cmd_error <= 1'b0;
			if (char_valid) begin
				case (state_q)
					`SCPIP_ST_KEY: begin
						if (key_end && len_q == 4'h0 && !qry_q) begin
							// A leading colon after a semicolon or at line start is the root.
							if (is_colon || is_nl)
								level_q <= {LEVEL_W{1'b0}};
						end else if (key_end) begin
							buf_q <= 96'h0;
							len_q <= 4'h0;
							star_q <= 1'b0;
							qry_q <= 1'b0;
							ovf_q <= 1'b0;
							if (!key_ok || bad_colon) begin
								cmd_error <= 1'b1;
								state_q <= is_nl ? `SCPIP_ST_KEY : `SCPIP_ST_SKIP;
								if (is_nl)
									level_q <= {LEVEL_W{1'b0}};
							end else begin
								kw_valid <= 1'b1;
								kw_id <= star_q ? `SCPIP_ID_NONE : match_id;
								kw_level <= key_level;
								kw_text <= buf_q;
								kw_common <= star_q;
								kw_query <= qry_q;
								kw_implied <= implied;
								cmd_qry_q <= qry_q;
								cmd_common_q <= star_q;
								got_param_q <= 1'b0;
								if (is_colon)
									level_q <= child_level;
								else if (star_q || is_nl)
									level_q <= {LEVEL_W{1'b0}};
								if (is_space)
									state_q <= `SCPIP_ST_PARAM;
								if (cmd_stop) begin
									cmd_end <= 1'b1;
									cmd_default <= 1'b1;
									resp_req <= qry_q;
								end
							end
						end else if (is_query) begin
							qry_q <= 1'b1;
						end else if (qry_q || len_q == `SCPIP_KEY_MAX) begin
							ovf_q <= 1'b1;
						end else begin
							buf_q <= {buf_q[87:0], ch_up};
							len_q <= len_q + 4'h1;
							if (len_q == 4'h0)
								star_q <= char_data == `SCPIP_CH_STAR;
						end
					end
					`SCPIP_ST_PARAM: begin
						if (cmd_stop) begin
							state_q <= `SCPIP_ST_KEY;
							cmd_end <= 1'b1;
							cmd_default <= !got_param_q;
							resp_req <= cmd_qry_q;
							if (is_nl || cmd_common_q)
								level_q <= {LEVEL_W{1'b0}};
						end else begin
							param_valid <= 1'b1;
							param_data <= char_data;
							got_param_q <= 1'b1;
						end
					end
					default: begin
						// Discard the rest of a bad command up to its separator.
						if (cmd_stop)
							state_q <= `SCPIP_ST_KEY;
						if (is_nl)
							level_q <= {LEVEL_W{1'b0}};
					end
				endcase
			end
		end
	end

endmodule

//--- test/scpip_assertions.sv
// Checker for the command text parser, bound to its top module.
// Assumes the parser sees one character per clock while char_valid is high.
`timescale 1ns/1ps
`include "scpip_map.vh"
module scpip_checker #(
	parameter LEVEL_W = 3
) (
	input wire clk,
	input wire sys_rst,
	input wire char_valid,
	input wire [7:0] char_data,
	input wire kw_valid,
	input wire [3:0] kw_id,
	input wire [LEVEL_W-1:0] kw_level,
	input wire [95:0] kw_text,
	input wire kw_common,
	input wire kw_query,
	input wire kw_implied,
	input wire param_valid,
	input wire cmd_end,
	input wire resp_req,
	input wire cmd_error
);
	// ==========================================================
	// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_com; kw_valid && kw_common |-> kw_id == 4'h0 && (kw_text[31:24] == `SCPIP_CH_STAR
		|| kw_text[39:32] == `SCPIP_CH_STAR || (kw_query && kw_text[23:16] == `SCPIP_CH_STAR));
		endproperty
	a_com: assert property (p_com) else $error("common keyword badly reported");
	property p_id; kw_valid && !kw_common |-> kw_id != 4'h0; endproperty
	a_id: assert property (p_id) else $error("accepted keyword without id");
	property p_imp; kw_valid && kw_implied |-> kw_level == LEVEL_W'(1); endproperty
	a_imp: assert property (p_imp) else $error("implied root level wrong");
	property p_err; cmd_error |-> !kw_valid; endproperty
	a_err: assert property (p_err) else $error("keyword accepted with error");
	property p_resp; resp_req |-> cmd_end && kw_query; endproperty
	a_resp: assert property (p_resp) else $error("response without query end");
	property p_prm; param_valid |-> $past(char_valid); endproperty
	a_prm: assert property (p_prm) else $error("parameter byte without input");
	property p_end; cmd_end |-> $past(char_valid) && ($past(char_data) == `SCPIP_CH_SEMI
		|| $past(char_data) == `SCPIP_CH_NL); endproperty
	a_end: assert property (p_end) else $error("command end without terminator");
	property p_kw; kw_valid |-> $past(char_valid) && $past(char_data) inside {`SCPIP_CH_COLON,
		`SCPIP_CH_SPACE, `SCPIP_CH_SEMI, `SCPIP_CH_NL}; endproperty
	a_kw: assert property (p_kw) else $error("keyword without separator");
	c_resp: cover property (resp_req);
	c_imp: cover property (kw_valid && kw_implied);
	c_err: cover property (cmd_error);
endmodule
bind scpip_parser scpip_checker #(.LEVEL_W(LEVEL_W)) i_scpip_checker (.clk, .sys_rst,
	.char_valid, .char_data, .kw_valid, .kw_id, .kw_level, .kw_text, .kw_common, .kw_query,
	.kw_implied, .param_valid, .cmd_end, .resp_req, .cmd_error);

//--- test/scpip_host.sv
// Host model that sends command text one character per clock.
// Assumes the caller waits until reset has been released.
`timescale 1ns/1ps
module scpip_host (
	input wire logic clk,
	output logic char_valid,
	output logic [7:0] char_data
);
	initial begin
		char_valid = 1'b0;
		char_data = 8'h00;
	end
	// Sends a whole line; the data lines show junk once released.
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk);
			char_valid <= 1'b1;
			char_data <= s[i];
		end
		@(posedge clk);
		char_valid <= 1'b0;
		char_data <= ~s[s.len()-1];
	endtask
endmodule

//--- test/scpi_command_syntax_parser_tb.sv
// Testbench for the command text parser, driven by the host model.
// Assumes a 100 MHz clock and keyword ids as handed over with the design.
`timescale 1ns/1ps
module scpi_command_syntax_parser_tb;
	logic clk;
	logic sys_rst = 1'b1;
	wire char_valid, kw_valid, kw_common, kw_query, kw_implied, param_valid;
	wire cmd_end, cmd_default, resp_req, cmd_error;
	wire [7:0] char_data, param_data;
	wire [3:0] kw_id;
	wire [95:0] kw_text;
	wire [2:0] kw_level;
	int err_total = 0, checks_done = 0, nk = 0, ne = 0, nn = 0, nr = 0, k0, e0, n0, r0;
	logic [9:0] last = 10'h000;
	logic dflt = 1'b0;
	logic [23:0] prm = 24'h00_0000;
	scpip_parser #(.LEVEL_W(3)) i_scpip_parser (.clk(clk), .sys_rst(sys_rst),
		.char_valid(char_valid), .char_data(char_data), .kw_valid(kw_valid), .kw_id(kw_id),
		.kw_level(kw_level), .kw_text(kw_text), .kw_common(kw_common), .kw_query(kw_query),
		.kw_implied(kw_implied), .param_valid(param_valid), .param_data(param_data),
		.cmd_end(cmd_end), .cmd_default(cmd_default), .resp_req(resp_req), .cmd_error(cmd_error));
	scpip_host i_scpip_host (.clk(clk), .char_valid(char_valid), .char_data(char_data));
	// ==========================================================
	// Event monitor.
	always @(posedge clk) begin
		if (kw_valid) begin
			nk <= nk + 1;
			last <= {kw_common, kw_query, kw_implied, kw_level, kw_id};
		end
		if (cmd_error === 1'b1) ne <= ne + 1;
		if (resp_req === 1'b1) nr <= nr + 1;
		if (param_valid === 1'b1) prm <= {prm[15:0], param_data};
		if (cmd_end === 1'b1) begin
			nn <= nn + 1;
			dflt <= cmd_default;
		end
	end
	// ==========================================================
	// Shared tasks.
	function automatic logic [9:0] ent(input logic c, q, i, input logic [2:0] l, input logic [3:0] d);
		return {c, q, i, l, d};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run(input string s);
		k0 = nk;
		e0 = ne;
		n0 = nn;
		r0 = nr;
		i_scpip_host.send(s);
		repeat (3) @(posedge clk);
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios.
	task automatic t_common;
		run("*rst\n");
		chk(last, ent(1'b1, 1'b0, 1'b0, 3'h0, 4'h0));
		chk(kw_text[31:0], 32'h2A52_5354);
		chk(dflt, 1'b1);
		run("*opc?\n");
		chk(nr - r0, 1);
		run("*ab\n");
		chk(ne - e0, 1);
		run("*abcde\n");
		chk(ne - e0, 1);
		run("*abcd\n");
		chk(ne - e0, 0);
	endtask
	task automatic t_keys;
		run("FREQ 5\n");
		chk(last, ent(1'b0, 1'b0, 1'b1, 3'h1, 4'h4));
		chk(prm[7:0], 8'h35);
		chk(dflt, 1'b0);
		run("FrEqUeNcY 1,2\n");
		chk(prm, 24'h31_2c32);
		run("FREQU 5\n");
		chk(ne - e0, 1);
		chk(nk - k0, 0);
		run("FUNC:SHAP SQU\n");
		chk(last, ent(1'b0, 1'b0, 1'b0, 3'h2, 4'h3));
		run("SYST:ERR?X\n");
		chk(ne - e0, 1);
	endtask
	task automatic t_tree;
		run("CAL:COUN?\n");
		chk(nk - k0, 2);
		chk(last, ent(1'b0, 1'b1, 1'b0, 3'h1, 4'h9));
		chk(nr - r0, 1);
		chk(dflt, 1'b1);
		run("calibration:count?\n");
		chk(last, ent(1'b0, 1'b1, 1'b0, 3'h1, 4'h9));
		run("CAL:SEC:CODE X;STAT ON\n");
		chk(last, ent(1'b0, 1'b0, 1'b0, 3'h2, 4'h7));
	endtask
	task automatic t_link;
		run("*RST;OUTP:LOAD 50;:SYST:ERR?\n");
		chk(nk - k0, 5);
		chk(nn - n0, 3);
		chk(ne - e0, 0);
		chk(last, ent(1'b0, 1'b1, 1'b0, 3'h1, 4'hd));
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		err_total++;
		final_report;
	end
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_common;
		t_keys;
		t_tree;
		t_link;
		final_report;
	end
endmodule
